// ### hdl/tune_dac_regs.svh
`ifndef TUNE_DAC_REGS_SVH
`define TUNE_DAC_REGS_SVH

// =============================================================
// Decoded host addresses
`define ADDR_STEER      8'h70
`define ADDR_LOAD       8'h71
`define ADDR_COMPARE    8'h80

// =============================================================
// Steering byte bit positions
`define STEER_FINE_HOLD     0
`define STEER_FINE_LO_EN    1
`define STEER_FINE_MID_EN   2
`define STEER_FINE_HI_EN    3
`define STEER_COARSE_HI_EN  4
`define STEER_COARSE_MID_EN 5
`define STEER_COARSE_LO_EN  6
`define STEER_COARSE_HOLD   7

// =============================================================
// Reset values and bus constants
`define STEER_RESET     8'hff
`define BYTE_RESET      8'h00
`define WB_BIT          7
`define SAR_FIRST_BIT   3'h7
`define WORD_BYTES      3'h7
`define LOAD_ZERO       8'h00
`define LOAD_HOLD_CLR   8'h00

`endif

// ### hdl/tune_dac_pkg.sv
package tune_dac_pkg;

   typedef enum logic [2:0] {
      st_idle  = 3'b000,
      st_steer = 3'b001,
      st_data  = 3'b011,
      st_hold  = 3'b010,
      st_clear = 3'b110,
      st_trial = 3'b111,
      st_look  = 3'b101,
      st_track = 3'b100
   } host_state_t;

   typedef struct packed {
      logic [7:0] lo;
      logic [7:0] mid;
      logic [7:0] hi;
   } side_latch_t;

endpackage : tune_dac_pkg

// ### hdl/tune_bus_if.sv
`timescale 1ns/100ps

// Host bus as seen by the converter loader: address, write strobe,
// data byte out of the host, and the open-drain write-back line on
// data bit 7 (output enable low while the device pulls it low).
interface tune_bus_if;
   logic [7:0] addr;
   logic       wr_strobe;
   logic [7:0] wdata;
   logic       cmp_sel;
   logic       wb_o;
   logic       wb_oe_n;
   logic       wb_line;

   // Open-drain resolution: the line floats high unless pulled.
   assign wb_line = wb_oe_n ? 1'b1 : wb_o;

   modport dev (
      input  addr,
      input  wr_strobe,
      input  wdata,
      input  cmp_sel,
      output wb_o,
      output wb_oe_n
   );

   modport host (
      output addr,
      output wr_strobe,
      output wdata,
      output cmp_sel,
      input  wb_line
   );
endinterface : tune_bus_if

// ### hdl/tune_side.sv
`timescale 1ns/100ps

// One converter side: three byte latches, hold level and write-back.
module tune_side
   import tune_dac_pkg::*;
(
   input  wire logic        clk,
   input  wire logic        srst,
   input  wire logic        load_stb,
   input  wire logic [7:0]  data,
   input  wire logic        lo_en_n,
   input  wire logic        mid_en_n,
   input  wire logic        hi_en_n,
   input  wire logic        hold_bit,
   input  wire logic        cmp_sel,
   input  wire logic        loop_err,
   output      logic [15:0] low_dac,
   output      logic [15:0] high_dac,
   output      logic        hold,
   output      logic        cmp_power,
   output      logic        pull_low
);
   `include "tune_dac_regs.svh"

   side_latch_t q_q;
   side_latch_t q_d;

   always_comb begin
      q_d = q_q;
      // A latch loads only when its steering line is low and the strobe is high.
      if (load_stb && !lo_en_n) begin
         q_d.lo = data;
      end
      if (load_stb && !mid_en_n) begin
         q_d.mid = data;
      end
      if (load_stb && !hi_en_n) begin
         q_d.hi = data;
      end
   end

   always_ff @(posedge clk) begin
      if (srst) begin
         q_q <= '{lo: `BYTE_RESET, mid: `BYTE_RESET, hi: `BYTE_RESET};
      end else begin
         q_q <= q_d;
      end
   end

   assign low_dac   = {q_q.mid, q_q.lo};
   assign high_dac  = {q_q.hi, q_q.mid};
   assign hold      = hold_bit;
   assign cmp_power = cmp_sel;
   assign pull_low  = cmp_sel & loop_err;
endmodule : tune_side

// ### hdl/tune_dac_loader.sv
// What this block does
// - Write at 70 captures the steering byte.
// - Write at 71 loads latches with low steering.
// - Host writes seven bytes, steering byte first.
// - Steering bits: holds at 0,7; enables between.
// - Hold bit high freezes that side's integrator.
// - Hold bit low means the side tracks.
// - Low, mid, high latches feed two converters.
// - 00 to both addresses gives positive full range.
// - FF at data gives negative full range.
// - Clear, steer 33, load 80 gives mid-range.
// - Compare decode powers both sides' write-back comparators.
// - Compare with high error pulls bit 7 low.
// - Host reads comparator after commanding hold.
// - Host runs successive approximation, then tracks.
`timescale 1ns/100ps

module tune_dac_loader
   import tune_dac_pkg::*;
(
   input  wire logic        clk,
   input  wire logic        srst,
   tune_bus_if.dev          bus,
   input  wire logic        coarse_loop_err,
   input  wire logic        fine_loop_err,
   output      logic [7:0]  steer_q_o,
   output      logic [15:0] coarse_low_dac,
   output      logic [15:0] coarse_high_dac,
   output      logic [15:0] fine_low_dac,
   output      logic [15:0] fine_high_dac,
   output      logic        coarse_hold_line,
   output      logic        fine_hold_line,
   output      logic        coarse_cmp_power,
   output      logic        fine_cmp_power
);
   `include "tune_dac_regs.svh"

   typedef struct packed {
      logic [7:0] steer;
   } loader_state_t;

   loader_state_t s_q;
   loader_state_t s_d;
   logic          load_stb;
   logic          c_pull;
   logic          f_pull;

   // =============================================================
   // Steering register
   always_comb begin
      s_d = s_q;
      if (bus.wr_strobe && bus.addr == `ADDR_STEER) begin
         s_d.steer = bus.wdata;
      end
   end

   // Reset leaves every latch disabled and both sides holding, so nothing
   // moves until software has written a steering byte.
   always_ff @(posedge clk) begin
      if (srst) begin
         s_q <= '{steer: `STEER_RESET};
      end else begin
         s_q <= s_d;
      end
   end

   // One data write lands in every enabled latch at once, which is what
   // lets a single 00 or FF byte set whole converters in one go.
   assign load_stb  = bus.wr_strobe && bus.addr == `ADDR_LOAD;
   assign steer_q_o = s_q.steer;

   // =============================================================
   // Converter sides, one instance each
   tune_side u_coarse (
      .clk       (clk),
      .srst      (srst),
      .load_stb  (load_stb),
      .data      (bus.wdata),
      .lo_en_n   (s_q.steer[`STEER_COARSE_LO_EN]),
      .mid_en_n  (s_q.steer[`STEER_COARSE_MID_EN]),
      .hi_en_n   (s_q.steer[`STEER_COARSE_HI_EN]),
      .hold_bit  (s_q.steer[`STEER_COARSE_HOLD]),
      .cmp_sel   (bus.cmp_sel),
      .loop_err  (coarse_loop_err),
      .low_dac   (coarse_low_dac),
      .high_dac  (coarse_high_dac),
      .hold      (coarse_hold_line),
      .cmp_power (coarse_cmp_power),
      .pull_low  (c_pull)
   );

   tune_side u_fine (
      .clk       (clk),
      .srst      (srst),
      .load_stb  (load_stb),
      .data      (bus.wdata),
      .lo_en_n   (s_q.steer[`STEER_FINE_LO_EN]),
      .mid_en_n  (s_q.steer[`STEER_FINE_MID_EN]),
      .hi_en_n   (s_q.steer[`STEER_FINE_HI_EN]),
      .hold_bit  (s_q.steer[`STEER_FINE_HOLD]),
      .cmp_sel   (bus.cmp_sel),
      .loop_err  (fine_loop_err),
      .low_dac   (fine_low_dac),
      .high_dac  (fine_high_dac),
      .hold      (fine_hold_line),
      .cmp_power (fine_cmp_power),
      .pull_low  (f_pull)
   );

   // =============================================================
   // Write-back: both comparators share data bit 7, wired-OR low.
   assign bus.wb_o    = 1'b0;
   assign bus.wb_oe_n = ~(c_pull | f_pull);
endmodule : tune_dac_loader

// ### hdl/tune_dac_host.sv
`timescale 1ns/100ps

// Host end: writes tuning words and runs successive approximation on
// the low-order converter of one side.
module tune_dac_host
   import tune_dac_pkg::*;
(
   input  wire logic        clk,
   input  wire logic        srst,
   tune_bus_if.host         bus,
   input  wire logic        word_go,
   input  wire logic [7:0]  word_steer,
   input  wire logic [47:0] word_data,
   input  wire logic        sar_go,
   input  wire logic        sar_coarse,
   output      logic        busy,
   output      logic [7:0]  sar_result
);
   `include "tune_dac_regs.svh"

   typedef struct packed {
      host_state_t st;
      logic [2:0]  cnt;
      logic [2:0]  bitn;
      logic [7:0]  trial;
      logic [47:0] data;
      logic [7:0]  steer;
      logic        coarse;
      logic [7:0]  result;
   } host_reg_t;

   host_reg_t h_q;
   host_reg_t h_d;
   logic [7:0] hold_steer;

   // Hold the chosen side with only its low latch enabled (enables low).
   always_comb begin
      hold_steer = 8'hff;
      if (h_q.coarse) begin
         hold_steer[`STEER_FINE_HOLD]    = 1'b0;
         hold_steer[`STEER_COARSE_LO_EN] = 1'b0;
      end else begin
         hold_steer[`STEER_COARSE_HOLD]  = 1'b0;
         hold_steer[`STEER_FINE_LO_EN]   = 1'b0;
      end
   end

   always_comb begin
      h_d = h_q;
      bus.addr      = `ADDR_STEER;
      bus.wr_strobe = 1'b0;
      bus.wdata     = `LOAD_ZERO;
      bus.cmp_sel   = 1'b0;
      case (h_q.st)
         st_idle: begin
            if (word_go) begin
               h_d.st    = st_steer;
               h_d.data  = word_data;
               h_d.steer = word_steer;
            end else if (sar_go) begin
               h_d.st     = st_hold;
               h_d.coarse = sar_coarse;
            end
         end
         st_steer: begin
            bus.wr_strobe = 1'b1;
            bus.wdata     = h_q.steer;
            h_d.st        = st_data;
            h_d.cnt       = 3'h1;
         end
         st_data: begin
            bus.addr      = `ADDR_LOAD;
            bus.wr_strobe = 1'b1;
            bus.wdata     = h_q.data[7:0];
            h_d.data      = {8'h00, h_q.data[47:8]};
            h_d.cnt       = 3'(h_q.cnt + 3'h1);
            if (h_d.cnt == `WORD_BYTES) begin
               h_d.st = st_idle;
            end
         end
         st_hold: begin
            bus.wr_strobe = 1'b1;
            bus.wdata     = hold_steer;
            h_d.st        = st_clear;
         end
         st_clear: begin
            bus.addr      = `ADDR_LOAD;
            bus.wr_strobe = 1'b1;
            bus.wdata     = `LOAD_ZERO;
            h_d.bitn      = `SAR_FIRST_BIT;
            h_d.trial     = `LOAD_ZERO;
            h_d.st        = st_trial;
         end
         st_trial: begin
            bus.addr      = `ADDR_LOAD;
            bus.wr_strobe = 1'b1;
            bus.wdata     = h_q.trial | (8'h01 << h_q.bitn);
            h_d.trial     = bus.wdata;
            h_d.st        = st_look;
         end
         st_look: begin
            bus.addr    = `ADDR_COMPARE;
            bus.cmp_sel = 1'b1;
            // A low line means the trial bit was too large: drop it.
            if (!bus.wb_line) begin
               h_d.trial[h_q.bitn] = 1'b0;
            end
            if (h_q.bitn == 3'h0) begin
               h_d.st = st_track;
            end else begin
               h_d.bitn = 3'(h_q.bitn - 3'h1);
               h_d.st   = st_trial;
            end
         end
         st_track: begin
            bus.addr      = `ADDR_LOAD;
            bus.wr_strobe = 1'b1;
            bus.wdata     = h_q.trial;
            h_d.result    = h_q.trial;
            h_d.steer     = `LOAD_HOLD_CLR;
            h_d.st        = st_steer;
            h_d.data      = '0;
         end
         default: h_d.st = st_idle;
      endcase
   end

   always_ff @(posedge clk) begin
      if (srst) begin
         h_q <= '{st: st_idle, cnt: 3'h0, bitn: 3'h0, trial: 8'h00, data: 48'h0,
                  steer: 8'h00, coarse: 1'b0, result: 8'h00};
      end else begin
         h_q <= h_d;
      end
   end

   assign busy       = h_q.st != st_idle;
   assign sar_result = h_q.result;
endmodule : tune_dac_host

// ### verif/tune_dac_assertions.sv
`timescale 1ns/100ps

// =============================================
// Protocol checks on the host/loader bus.
module tune_dac_assertions (
   input wire logic       clk,
   input wire logic       srst,
   input wire logic [7:0] addr,
   input wire logic       wr_strobe,
   input wire logic [7:0] wdata,
   input wire logic       cmp_sel,
   input wire logic       wb_o,
   input wire logic       wb_oe_n,
   input wire logic       wb_line
);
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (srst);

   property p_wb_zero;
      wb_o == 1'b0;
   endproperty
   a_wb_zero: assert property (p_wb_zero)
      else $error("write-back drives a high level");
   property p_pull_cause;
      !wb_oe_n |-> cmp_sel;
   endproperty
   a_pull_cause: assert property (p_pull_cause)
      else $error("write-back pulls without compare");
   property p_release;
      !cmp_sel |-> wb_oe_n && wb_line;
   endproperty
   a_release: assert property (p_release)
      else $error("released line not high");
   property p_wr_addr;
      wr_strobe |-> addr inside {8'h70, 8'h71};
   endproperty
   a_wr_addr: assert property (p_wr_addr)
      else $error("write to unmapped address");
   property p_steer_load;
      wr_strobe && addr == 8'h70 |=> ##[0:1] (wr_strobe && addr == 8'h71);
   endproperty
   a_steer_load: assert property (p_steer_load)
      else $error("steering byte not followed by data");
   property p_look;
      $rose(cmp_sel) |-> $past(wr_strobe) && $past(addr) == 8'h71;
   endproperty
   a_look: assert property (p_look)
      else $error("compare without a trial write");
   property p_cmp_quiet;
      cmp_sel |-> !wr_strobe && addr == 8'h80;
   endproperty
   a_cmp_quiet: assert property (p_cmp_quiet)
      else $error("compare cycle not at compare address");
   property p_look_bound;
      $rose(cmp_sel) |-> ##[1:4] !cmp_sel;
   endproperty
   a_look_bound: assert property (p_look_bound)
      else $error("compare held too long");

   cover property (!wb_oe_n);
   cover property (wr_strobe && wdata == 8'hff);
   cover property ($rose(cmp_sel));
endmodule : tune_dac_assertions

// ### verif/testbench.sv
`timescale 1ns/100ps

module testbench;
   logic        clk = 1'b0;
   logic        srst = 1'b1;
   logic        c_err = 1'b0;
   logic        f_err = 1'b0;
   logic        go = 1'b0;
   logic        sgo = 1'b0;
   logic        scoarse = 1'b0;
   logic        busy, ch_l, fh_l, cp, fp;
   logic [7:0]  ws = 8'h00;
   logic [47:0] wd = 48'h0;
   logic [7:0]  tgt_c = 8'hff;
   logic [7:0]  tgt_f = 8'hff;
   logic [7:0]  stq, res, st;
   logic [15:0] cl, ch, fl, fh;
   logic [7:0]  lat [1:6];
   logic [55:0] tab [5] = '{{8'h00, 48'hffffffffffff}, {8'h00, 48'h0},
      {8'h33, 48'h808080808080}, {8'h81, 48'h0123456789ab},
      {8'h7e, 48'h5555aaaa5555}};
   int          fails = 0;
   int          n_compared = 0;

   tune_bus_if bus ();
   tune_dac_loader i_tune_dac_loader (.clk(clk), .srst(srst), .bus(bus),
      .coarse_loop_err(c_err), .fine_loop_err(f_err), .steer_q_o(stq),
      .coarse_low_dac(cl), .coarse_high_dac(ch), .fine_low_dac(fl),
      .fine_high_dac(fh), .coarse_hold_line(ch_l), .fine_hold_line(fh_l),
      .coarse_cmp_power(cp), .fine_cmp_power(fp));
   tune_dac_host i_tune_dac_host (.clk(clk), .srst(srst), .bus(bus),
      .word_go(go), .word_steer(ws), .word_data(wd), .sar_go(sgo),
      .sar_coarse(scoarse), .busy(busy), .sar_result(res));
   tune_dac_assertions u_chk (.clk(clk), .srst(srst), .addr(bus.addr),
      .wr_strobe(bus.wr_strobe), .wdata(bus.wdata), .cmp_sel(bus.cmp_sel),
      .wb_o(bus.wb_o), .wb_oe_n(bus.wb_oe_n), .wb_line(bus.wb_line));

   always #25 clk = ~clk;

   // =============================================
   // Comparator model: error is high when the trial code is too large.
   always @(negedge clk) begin
      c_err <= cl[7:0] > tgt_c;
      f_err <= fl[7:0] > tgt_f;
      if (!srst) chk("cmp_power", {14'h0, {2{bus.cmp_sel}}}, {14'h0, cp, fp});
   end

   task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
      n_compared++;
      if (g !== e) begin
         fails++;
         $display("[ERR] %s exp %h got %h", nm, e, g);
      end
   endtask : chk

   task automatic wait_idle;
      int k;
      k = 0;
      @(negedge clk);
      while (busy !== 1'b0 && k < 200) begin
         @(negedge clk);
         k++;
      end
      chk("busy", 16'h0, {15'h0, busy});
   endtask : wait_idle

   task automatic word(input logic [7:0] s, input logic [47:0] d);
      @(negedge clk);
      ws = s;
      wd = d;
      go = 1'b1;
      @(negedge clk);
      go = 1'b0;
      wait_idle();
      for (int b = 0; b < 6; b++)
         for (int i = 1; i < 7; i++)
            if (!s[i]) lat[i] = d[8*b +: 8];
      st = s;
   endtask : word

   // Only the low byte of the side is searched, so the other side's
   // comparator is kept quiet to leave the shared bit 7 to this side.
   task automatic sar(input logic c, input logic [7:0] t);
      @(negedge clk);
      tgt_c = c ? t : 8'hff;
      tgt_f = c ? 8'hff : t;
      scoarse = c;
      sgo = 1'b1;
      @(negedge clk);
      sgo = 1'b0;
      wait_idle();
      chk("sar_result", {8'h0, t}, {8'h0, res});
      st = 8'h00;
      foreach (lat[i]) lat[i] = 8'h00;
   endtask : sar

   task automatic check_all;
      chk("steer", {8'h0, st}, {8'h0, stq});
      chk("fine_hold", {15'h0, st[0]}, {15'h0, fh_l});
      chk("coarse_hold", {15'h0, st[7]}, {15'h0, ch_l});
      chk("fine_low", {lat[2], lat[1]}, fl);
      chk("fine_high", {lat[3], lat[2]}, fh);
      chk("coarse_low", {lat[5], lat[6]}, cl);
      chk("coarse_high", {lat[4], lat[5]}, ch);
   endtask : check_all

   task automatic tally_and_finish;
      $display("compared %0d failed %0d", n_compared, fails);
      if (fails == 0 && n_compared > 0) $display("Regression OK");
      else $display("Regression broken");
      $finish;
   endtask : tally_and_finish

   initial begin
      repeat (4) @(posedge clk);
      @(negedge clk);
      srst = 1'b0;
      st = 8'hff;
      foreach (lat[i]) lat[i] = 8'h00;
      check_all();
      $display("test reset done");
      for (int t = 0; t < 5; t++) begin
         word(tab[t][55:48], tab[t][47:0]);
         check_all();
         $display("test word %0d done", t);
      end
      sar(1'b1, 8'h5a);
      check_all();
      sar(1'b0, 8'ha5);
      check_all();
      $display("test sar done");
      tally_and_finish();
   end

   initial begin
      repeat (3000) @(posedge clk);
      fails++;
      tally_and_finish();
   end
endmodule : testbench
